// ==== design/gpio_port_pkg.sv ====
// Constants for the shared parallel I/O port.
// Assumes a single system clock and a synchronous active-low reset.
package gpio_port_pkg;

  // ----------------------------------------------------------------------
  // Port geometry
  // ----------------------------------------------------------------------
  localparam int unsigned PORT_WIDTH = 16;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [PORT_WIDTH-1:0] DIR_RESET   = 16'hffff;
  localparam logic [PORT_WIDTH-1:0] LATCH_RESET = 16'h0000;

  // ----------------------------------------------------------------------
  // Direction encoding
  // ----------------------------------------------------------------------
  localparam logic DIR_INPUT  = 1'b1;
  localparam logic DIR_OUTPUT = 1'b0;

  // ----------------------------------------------------------------------
  // Software access selectors
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    SEL_DIRECTION,
    SEL_LATCH,
    SEL_PIN_LEVEL,
    SEL_NONE
  } reg_sel_t;

endpackage

// ==== design/shared_parallel_io_port.sv ====
// Shared parallel I/O port: direction, latch and pin-level registers,
// with per-pin output muxes that give enabled peripherals precedence.
// Assumes pads are synchronous to nothing; pin inputs are resynchronised.
`timescale 1ns/1ps

module shared_parallel_io_port
  import gpio_port_pkg::*;
#(
  parameter int unsigned              WIDTH       = PORT_WIDTH,
  parameter logic [PORT_WIDTH-1:0]    IMPL_MASK   = 16'hffff,
  parameter logic [PORT_WIDTH-1:0]    PERIPH_OUT  = 16'hffff
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              resetn,
  // Software access
  input  wire reg_sel_t          sw_sel,
  input  wire logic              sw_wr,
  input  wire logic [WIDTH-1:0]  sw_wdata,
  output logic [WIDTH-1:0]       sw_rdata,
  // Peripheral side
  input  wire logic [WIDTH-1:0]  periph_active,
  input  wire logic [WIDTH-1:0]  periph_out,
  // Pad cells
  input  wire logic [WIDTH-1:0]  pad_in,
  output logic [WIDTH-1:0]       pad_out,
  output logic [WIDTH-1:0]       pad_oe
);

  // ----------------------------------------------------------------------
  // Masks
  // ----------------------------------------------------------------------
  // Pins whose alternate function is input only never see the peripheral
  // mux, so PERIPH_OUT clears them (external_irq_line_four and the like).
  logic [WIDTH-1:0] impl_m;
  logic [WIDTH-1:0] share_m;
  assign impl_m  = IMPL_MASK[WIDTH-1:0];
  assign share_m = PERIPH_OUT[WIDTH-1:0] & impl_m;

  // ----------------------------------------------------------------------
  // Pin input synchroniser
  // ----------------------------------------------------------------------
  logic [WIDTH-1:0] pin_meta_r;
  logic [WIDTH-1:0] pin_sync_r;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      pin_meta_r <= '0;
      pin_sync_r <= '0;
    end else begin
      pin_meta_r <= pad_in;
      pin_sync_r <= pin_meta_r;
    end
  end

  // ----------------------------------------------------------------------
  // Direction and latch registers
  // ----------------------------------------------------------------------
  logic [WIDTH-1:0] pin_direction_reg_r;
  logic [WIDTH-1:0] output_latch_reg_r;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      pin_direction_reg_r <= DIR_RESET[WIDTH-1:0];
    end else if (sw_wr && sw_sel == SEL_DIRECTION) begin
      // Unimplemented bits held at input so they never drive
      pin_direction_reg_r <= sw_wdata | ~impl_m;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      output_latch_reg_r <= LATCH_RESET[WIDTH-1:0];
    end else if (sw_wr && (sw_sel == SEL_LATCH ||
                           sw_sel == SEL_PIN_LEVEL)) begin
      output_latch_reg_r <= sw_wdata & impl_m;
    end
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  // Registered read costs a cycle but keeps every output on a flop.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sw_rdata <= '0;
    end else begin
      case (sw_sel)
        SEL_DIRECTION: sw_rdata <= pin_direction_reg_r & impl_m;
        SEL_LATCH:     sw_rdata <= output_latch_reg_r;
        SEL_PIN_LEVEL: sw_rdata <= pin_sync_r & impl_m;
        default:       sw_rdata <= '0;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Output muxes
  // ----------------------------------------------------------------------
  logic [WIDTH-1:0] own_m;
  logic [WIDTH-1:0] port_oe;
  logic [WIDTH-1:0] oe_nxt;
  logic [WIDTH-1:0] out_nxt;

  assign own_m   = periph_active & share_m;
  assign port_oe = ~pin_direction_reg_r & impl_m;
  assign oe_nxt  = (own_m | port_oe) & impl_m;
  assign out_nxt = (own_m & periph_out) |
                   (~own_m & output_latch_reg_r);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      pad_oe  <= '0;
      pad_out <= '0;
    end else begin
      pad_oe  <= oe_nxt;
      pad_out <= out_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Checks: reset, masks and pin synchroniser
  // ----------------------------------------------------------------------
  a_reset_all_input: assert property (
    @(posedge clk)
    !resetn |=> pad_oe == '0 && &(pin_direction_reg_r | ~impl_m))
    else $error("pins not inputs after reset");

  a_reset_out_quiet: assert property (
    @(posedge clk)
    !resetn |=> pad_out == '0 && sw_rdata == '0)
    else $error("pad data or read data not clear after reset");

  a_reset_latch_clear: assert property (
    @(posedge clk)
    !resetn |=> output_latch_reg_r == LATCH_RESET[WIDTH-1:0])
    else $error("latch not cleared by reset");

  a_unimpl_zero: assert property (
    @(posedge clk) disable iff (!resetn)
    (sw_rdata & ~impl_m) == '0 && (pad_oe & ~impl_m) == '0)
    else $error("unimplemented bit not zero");

  a_unimpl_dir_input: assert property (
    @(posedge clk) disable iff (!resetn)
    &(pin_direction_reg_r | impl_m))
    else $error("unimplemented direction bit left as output");

  a_unimpl_latch_zero: assert property (
    @(posedge clk) disable iff (!resetn)
    (output_latch_reg_r & ~impl_m) == '0)
    else $error("unimplemented latch bit set");

  a_unimpl_no_data: assert property (
    @(posedge clk) disable iff (!resetn)
    (pad_out & ~impl_m) == '0)
    else $error("unimplemented pad data set");

  a_sync_first_stage: assert property (
    @(posedge clk) disable iff (!resetn)
    ##1 1 |-> pin_meta_r == $past(pad_in))
    else $error("first sync stage missed the pad");

  a_sync_two_stage: assert property (
    @(posedge clk) disable iff (!resetn)
    ##1 1 |-> pin_sync_r == $past(pin_meta_r))
    else $error("second sync stage missed the first");

  // ----------------------------------------------------------------------
  // Checks: software access
  // ----------------------------------------------------------------------
  a_dir_write: assert property (
    @(posedge clk) disable iff (!resetn)
    sw_wr && sw_sel == SEL_DIRECTION
    |=> pin_direction_reg_r == ($past(sw_wdata) | ~impl_m))
    else $error("direction write lost");

  a_dir_hold: assert property (
    @(posedge clk) disable iff (!resetn)
    !(sw_wr && sw_sel == SEL_DIRECTION) |=> $stable(pin_direction_reg_r))
    else $error("direction changed without a write");

  a_dir_readback: assert property (
    @(posedge clk) disable iff (!resetn)
    sw_sel == SEL_DIRECTION
    |=> sw_rdata == ($past(pin_direction_reg_r) & impl_m))
    else $error("direction read wrong");

  a_latch_write: assert property (
    @(posedge clk) disable iff (!resetn)
    sw_wr && sw_sel == SEL_LATCH ##1 sw_sel == SEL_LATCH
    |=> sw_rdata == ($past(sw_wdata, 2) & impl_m))
    else $error("latch readback wrong");

  a_latch_direct: assert property (
    @(posedge clk) disable iff (!resetn)
    sw_wr && sw_sel == SEL_LATCH
    |=> output_latch_reg_r == ($past(sw_wdata) & impl_m))
    else $error("latch write lost");

  a_latch_read: assert property (
    @(posedge clk) disable iff (!resetn)
    sw_sel == SEL_LATCH |=> sw_rdata == $past(output_latch_reg_r))
    else $error("latch read did not return the latch");

  a_latch_hold: assert property (
    @(posedge clk) disable iff (!resetn)
    !(sw_wr && (sw_sel == SEL_LATCH || sw_sel == SEL_PIN_LEVEL))
    |=> $stable(output_latch_reg_r))
    else $error("latch changed without a write");

  a_none_write_ignored: assert property (
    @(posedge clk) disable iff (!resetn)
    sw_wr && sw_sel == SEL_NONE
    |=> $stable(output_latch_reg_r) && $stable(pin_direction_reg_r))
    else $error("unselected write changed a register");

  a_pin_write_latch: assert property (
    @(posedge clk) disable iff (!resetn)
    sw_wr && sw_sel == SEL_PIN_LEVEL
    |=> output_latch_reg_r == ($past(sw_wdata) & impl_m))
    else $error("pin-level write missed latch");

  a_pin_write_no_dir: assert property (
    @(posedge clk) disable iff (!resetn)
    sw_wr && sw_sel == SEL_PIN_LEVEL |=> $stable(pin_direction_reg_r))
    else $error("pin-level write changed direction");

  a_pin_read_sync: assert property (
    @(posedge clk) disable iff (!resetn)
    sw_sel == SEL_PIN_LEVEL && $past(resetn) && $past(resetn, 2)
    |=> sw_rdata == ($past(pad_in, 3) & impl_m))
    else $error("pin read mismatch");

  a_pin_read_mask: assert property (
    @(posedge clk) disable iff (!resetn)
    sw_sel == SEL_PIN_LEVEL |=> sw_rdata == ($past(pin_sync_r) & impl_m))
    else $error("pin read not from the synchroniser");

  // ----------------------------------------------------------------------
  // Checks: output muxes
  // ----------------------------------------------------------------------
  a_periph_owns_pin: assert property (
    @(posedge clk) disable iff (!resetn)
    ##1 1 |-> ((pad_out ^ $past(periph_out)) & $past(own_m)) == '0)
    else $error("active peripheral not driving its pin");

  a_periph_enable_pin: assert property (
    @(posedge clk) disable iff (!resetn)
    ##1 1 |-> ($past(own_m) & ~pad_oe) == '0)
    else $error("active peripheral pin not enabled");

  a_periph_by_input: assert property (
    @(posedge clk) disable iff (!resetn)
    ##1 1 |-> ((pad_out ^ $past(periph_out))
               & $past(periph_active & share_m)) == '0)
    else $error("port data reached a peripheral-owned pin");

  a_idle_periph_port: assert property (
    @(posedge clk) disable iff (!resetn)
    ##1 1 |-> (($past(~own_m & port_oe)) & ~pad_oe) == '0)
    else $error("idle peripheral blocked port driver");

  a_idle_periph_data: assert property (
    @(posedge clk) disable iff (!resetn)
    ##1 1 |-> ((pad_out ^ $past(output_latch_reg_r))
               & $past(~periph_active & share_m)) == '0)
    else $error("idle peripheral pin not fed from latch");

  a_shared_active_only: assert property (
    @(posedge clk) disable iff (!resetn)
    ##1 1 |-> ((pad_oe ^ $past(port_oe)) & $past(~periph_active)) == '0)
    else $error("inactive peripheral changed the pad enable");

  a_input_no_drive: assert property (
    @(posedge clk) disable iff (!resetn)
    ##1 1 |-> ($past(pin_direction_reg_r & ~own_m) & pad_oe) == '0)
    else $error("input pin driven by port");

  a_oe_needs_owner: assert property (
    @(posedge clk) disable iff (!resetn)
    ##1 1 |-> (pad_oe & ~$past(own_m | port_oe)) == '0)
    else $error("pad enabled with no owner");

  a_mux_pair_oe: assert property (
    @(posedge clk) disable iff (!resetn)
    ##1 1 |-> pad_oe == $past(((periph_active & share_m) |
                               ~pin_direction_reg_r) & impl_m))
    else $error("pad enable mux wrong");

  a_input_only_fn: assert property (
    @(posedge clk) disable iff (!resetn)
    ##1 1 |-> ((pad_oe ^ $past(port_oe)) & ~share_m) == '0)
    else $error("input-only pin lost port control");

  a_input_only_data: assert property (
    @(posedge clk) disable iff (!resetn)
    ##1 1 |-> ((pad_out ^ $past(output_latch_reg_r)) & ~share_m) == '0)
    else $error("input-only pin data not from latch");

  a_port_drives_latch: assert property (
    @(posedge clk) disable iff (!resetn)
    ##1 1 |-> ((pad_out ^ $past(output_latch_reg_r))
               & $past(port_oe & ~own_m)) == '0)
    else $error("port pin not driving latch");

  a_dir_out_drive: assert property (
    @(posedge clk) disable iff (!resetn)
    ##1 1 |-> ($past(~pin_direction_reg_r & impl_m) & ~pad_oe) == '0)
    else $error("output pin not enabled");

endmodule // shared_parallel_io_port

// ==== verif/pad_model.sv ====
// Pad model: resolves every pin from the port driver or the outside.
// Assumes the outside drives ext_lvl on each pin the port leaves alone.
`timescale 1ns/1ps
module pad_model (
  // Port side
  input  wire logic [15:0] pad_out,
  input  wire logic [15:0] pad_oe,
  // Outside world
  input  wire logic [15:0] ext_lvl,
  output logic      [15:0] pad_in
);
  // --------------------------------------------------------------------
  // Pin resolution
  // --------------------------------------------------------------------
  // Outside source steps back where enabled, so no fight is modelled
  assign pad_in = (pad_out & pad_oe) | (ext_lvl & ~pad_oe);
endmodule // pad_model

// ==== verif/test_shared_parallel_io_port.sv ====
// Testbench: register access, pad drivers and peripheral precedence.
// Assumes the pad model loops pad_out back to pad_in on enabled pins and feeds ext elsewhere.
`timescale 1ns/1ps
module test_shared_parallel_io_port;
  import gpio_port_pkg::*;
  // --------------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------------
  localparam logic [15:0] IMPL = 16'h7fff;
  localparam logic [15:0] POUT = 16'hfffe; // Bit 0 input-only alternate
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  reg_sel_t    sw_sel = SEL_NONE;
  logic        sw_wr = 1'b0;
  logic [15:0] sw_wdata = 16'h0000;
  logic [15:0] act = 16'h0000;
  logic [15:0] pout = 16'h0000;
  logic [15:0] ext = 16'hc3aa;
  logic [15:0] sw_rdata;
  logic [15:0] pad_in;
  logic [15:0] pad_out;
  logic [15:0] pad_oe;
  int          n_mismatch = 0;
  int          num_checks = 0;
  always #50 clk = ~clk;
  shared_parallel_io_port #(.IMPL_MASK(IMPL), .PERIPH_OUT(POUT)) dut (
    .clk(clk), .resetn(resetn), .sw_sel(sw_sel), .sw_wr(sw_wr),
    .sw_wdata(sw_wdata), .sw_rdata(sw_rdata), .periph_active(act),
    .periph_out(pout), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe));
  pad_model pads (.pad_out(pad_out), .pad_oe(pad_oe), .ext_lvl(ext),
    .pad_in(pad_in));
  // --------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------
  task automatic chk(input logic [15:0] got, exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Idle cycle after the strobe so a following write never retoggles it
  task automatic wr(input reg_sel_t s, input logic [15:0] d);
    sw_sel = s;
    sw_wr = 1'b1;
    sw_wdata = d;
    tick(1);
    sw_wr = 1'b0;
    tick(1);
  endtask
  // Four edges cover both the read register and the pin synchroniser
  task automatic rd(input reg_sel_t s, input logic [15:0] exp);
    sw_sel = s;
    tick(4);
    chk(sw_rdata, exp, "read");
  endtask
  task automatic pins(input logic [15:0] dir, lat, input string t);
    logic [15:0] own;
    logic [15:0] eo;
    logic [15:0] eout;
    own = act & POUT & IMPL;
    eo = (~dir | own) & IMPL;
    eout = (pout & own) | (lat & ~own);
    tick(3);
    chk(pad_oe, eo, "pad enable");
    chk(pad_out & eo, eout & eo, "pad data");
    rd(SEL_PIN_LEVEL, ((eout & eo) | (ext & ~eo)) & IMPL);
    $display("test %s done", t);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // --------------------------------------------------------------------
  // Sequence
  // --------------------------------------------------------------------
  initial begin
    tick(20);
    chk(pad_oe, 16'h0000, "reset enable");
    resetn = 1'b1;
    rd(SEL_DIRECTION, IMPL);
    rd(SEL_LATCH, 16'h0000);
    $display("test reset done");
    wr(SEL_LATCH, 16'hffff);
    rd(SEL_LATCH, IMPL);
    wr(SEL_PIN_LEVEL, 16'h1234);
    rd(SEL_LATCH, 16'h1234);
    wr(SEL_NONE, 16'hffff);
    rd(SEL_LATCH, 16'h1234);
    $display("test latch done");
    wr(SEL_DIRECTION, 16'h0000);
    rd(SEL_DIRECTION, 16'h0000);
    pins(16'h0000, 16'h1234, "all outputs");
    wr(SEL_DIRECTION, 16'h00ff);
    pins(16'h00ff, 16'h1234, "mixed");
    act = 16'h8f0f;
    pout = 16'h0505;
    pins(16'h00ff, 16'h1234, "peripheral");
    act = 16'h0000;
    ext = 16'h3c5f;
    pins(16'h00ff, 16'h1234, "peripheral idle");
    resetn = 1'b0;
    tick(2);
    chk(pad_oe, 16'h0000, "second reset enable");
    resetn = 1'b1;
    rd(SEL_DIRECTION, IMPL);
    $display("test second reset done");
    test_done();
  end
endmodule // test_shared_parallel_io_port
